/* File: design/comparator_vref_control_regs.vh */
// register map, field positions, reset values and timing counts of the comparator and reference control block
// assumes an 8-bit register address space and a 100 MHz core clock
`ifndef COMPARATOR_VREF_CONTROL_REGS_VH
`define COMPARATOR_VREF_CONTROL_REGS_VH

// register offsets
`define PORT_PINS_ADDR        8'h05
`define CHANGE_FLAG_ADDR      8'h0c
`define CMP_CTRL_ADDR         8'h19
`define PORT_DIR_ADDR         8'h85
`define REF_CTRL_ADDR         8'h99

// comparator_control fields
`define CMP_MODE_LSB          0
`define CMP_MODE_MSB          2
`define CMP_INSEL_BIT         3
`define CMP_INVERT_BIT        4
`define CMP_RESULT_BIT        6
`define CMP_CTRL_RESET        8'h00

// reference_control fields
`define REF_LEVEL_LSB         0
`define REF_LEVEL_MSB         3
`define REF_RANGE_BIT         5
`define REF_ENABLE_BIT        7
`define REF_CTRL_RESET        8'h00

// flag register field
`define CHANGE_FLAG_BIT       3
`define CHANGE_FLAG_RESET     1'b0

// port direction: one bit per pin, set means input
`define PORT_DIR_RESET        6'h3f
`define OUT_PIN_BIT           2

// comparator modes
`define MODE_RESET            3'h0
`define MODE_OFF              3'h7

// timing
`define CLK_PERIOD_NS         10
`define SETTLE_TIME_NS        10000

`endif

/* File: design/comparator_vref_control.v */
// comparator and voltage reference control: registers, mode decode, result path, change flag, output pin
// assumes a raw comparator result and port pins that arrive asynchronously from the analog side,
// and a single core clock with a synchronous active-low reset
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`include "comparator_vref_control_regs.vh"

module comparator_vref_control #(
   parameter NUM_PINS = 6
) (
   // clock and reset
   input  wire                core_clk_i,
   input  wire                rst_b_i,
   // register port
   input  wire [7:0]          reg_addr_i,
   input  wire [7:0]          reg_wdata_i,
   input  wire                reg_wr_i,
   input  wire                reg_rd_i,
   output wire [7:0]          reg_rdata_o,
   // analog side
   input  wire                cmp_raw_i,
   input  wire [NUM_PINS-1:0] pin_in_i,
   output wire [2:0]          comparator_mode_o,
   output wire                comparator_on_o,
   output wire                input_select_o,
   output wire                ref_route_o,
   output wire                reference_enable_o,
   output wire                reference_range_o,
   output wire [3:0]          reference_level_o,
   output wire [NUM_PINS-1:0] pin_analog_o,
   // result and events
   output wire                result_valid_o,
   output wire                comparator_change_flag_o,
   // output pin
   output wire                output_pin_o,
   output wire                output_pin_oe_b_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // constants and decode functions

   // least wait: round up to whole cycles
   localparam integer SETTLE_CYC = (`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam [9:0]   SETTLE_MAX = SETTLE_CYC[9:0];
   // reset images of the two control registers, so single fields can be picked out at full width
   localparam [7:0]   CMP_RST    = `CMP_CTRL_RESET;
   localparam [7:0]   REF_RST    = `REF_CTRL_RESET;

   // modes that drive the result to the output pin
   function mode_has_output;
      input [2:0] mode;
      begin
         case (mode)
            3'h1:    mode_has_output = 1'b1;
            3'h3:    mode_has_output = 1'b1;
            3'h5:    mode_has_output = 1'b1;
            default: mode_has_output = 1'b0;
         endcase
      end
   endfunction

   // modes that use the internal reference
   function mode_uses_ref;
      input [2:0] mode;
      begin
         case (mode)
            3'h3:    mode_uses_ref = 1'b1;
            3'h4:    mode_uses_ref = 1'b1;
            3'h5:    mode_uses_ref = 1'b1;
            3'h6:    mode_uses_ref = 1'b1;
            default: mode_uses_ref = 1'b0;
         endcase
      end
   endfunction

   // which of the three comparator pins are analog
   function [2:0] mode_analog_mask;
      input [2:0] mode;
      begin
         case (mode)
            `MODE_RESET: mode_analog_mask = 3'h7;
            `MODE_OFF:   mode_analog_mask = 3'h0;
            default:     mode_analog_mask = 3'h3;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   reg  [2:0]          mode_ff;
   reg                 insel_ff;
   reg                 invert_ff;
   reg                 ref_en_ff;
   reg                 ref_range_ff;
   reg  [3:0]          ref_level_ff;
   reg  [NUM_PINS-1:0] port_dir_ff;
   reg                 flag_ff;
   reg                 latched_ff;
   reg  [9:0]          settle_ff;
   reg  [7:0]          rdata_ff;
   reg                 cmp_meta_ff;
   reg                 cmp_sync_ff;
   reg  [NUM_PINS-1:0] pin_meta_ff;
   reg  [NUM_PINS-1:0] pin_sync_ff;

   wire wr_cmp  = reg_wr_i & (reg_addr_i == `CMP_CTRL_ADDR);
   wire rd_cmp  = reg_rd_i & (reg_addr_i == `CMP_CTRL_ADDR);
   wire wr_ref  = reg_wr_i & (reg_addr_i == `REF_CTRL_ADDR);
   wire wr_dir  = reg_wr_i & (reg_addr_i == `PORT_DIR_ADDR);
   wire wr_flag = reg_wr_i & (reg_addr_i == `CHANGE_FLAG_ADDR);

   wire [2:0] new_mode = reg_wdata_i[`CMP_MODE_MSB:`CMP_MODE_LSB];

   always @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         mode_ff      <= `MODE_RESET;
         insel_ff     <= CMP_RST[`CMP_INSEL_BIT];
         invert_ff    <= CMP_RST[`CMP_INVERT_BIT];
         ref_en_ff    <= REF_RST[`REF_ENABLE_BIT];
         ref_range_ff <= REF_RST[`REF_RANGE_BIT];
         ref_level_ff <= REF_RST[`REF_LEVEL_MSB:`REF_LEVEL_LSB];
         port_dir_ff  <= `PORT_DIR_RESET;
      end else begin
         // the result bit is not stored here, so writes cannot touch it
         // no sleep input exists: wake leaves every register as it was
         if (wr_cmp) begin
            mode_ff   <= new_mode;
            insel_ff  <= reg_wdata_i[`CMP_INSEL_BIT];
            invert_ff <= reg_wdata_i[`CMP_INVERT_BIT];
         end
         if (wr_ref) begin
            ref_en_ff    <= reg_wdata_i[`REF_ENABLE_BIT];
            ref_range_ff <= reg_wdata_i[`REF_RANGE_BIT];
            ref_level_ff <= reg_wdata_i[`REF_LEVEL_MSB:`REF_LEVEL_LSB];
         end
         if (wr_dir) begin
            port_dir_ff <= reg_wdata_i[NUM_PINS-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // synchronisers: the first stage feeds only the second

   always @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         cmp_meta_ff <= 1'b0;
         cmp_sync_ff <= 1'b0;
         pin_meta_ff <= {NUM_PINS{1'b0}};
         pin_sync_ff <= {NUM_PINS{1'b0}};
      end else begin
         cmp_meta_ff <= cmp_raw_i;
         cmp_sync_ff <= cmp_meta_ff;
         pin_meta_ff <= pin_in_i;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // result path and settling

   wire cmp_on  = (mode_ff != `MODE_RESET) & (mode_ff != `MODE_OFF);
   // raw input is high when positive input exceeds negative
   wire result  = cmp_on & (cmp_sync_ff ^ invert_ff);
   wire settling = (settle_ff != 10'h000);

   // a write that changes the mode restarts the wait, since the analog side may re-route inputs
   always @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         settle_ff <= 10'h000;
      end else if (wr_cmp && (new_mode != mode_ff)) begin
         settle_ff <= SETTLE_MAX;
      end else if (settling) begin
         settle_ff <= settle_ff - 10'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // change flag

   // a mismatch keeps setting the flag until an access re-latches the result
   wire mismatch = (result != latched_ff) & ~settling;
   wire cmp_acc  = wr_cmp | rd_cmp;

   always @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         latched_ff <= 1'b0;
         flag_ff    <= `CHANGE_FLAG_RESET;
      end else begin
         if (cmp_acc || settling) begin
            latched_ff <= result;
         end
         // set wins over a software clear in the same cycle
         if (mismatch) begin
            flag_ff <= 1'b1;
         end else if (wr_flag) begin
            flag_ff <= reg_wdata_i[`CHANGE_FLAG_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read data, one cycle after the strobe and zero otherwise

   wire [2:0]          cmp_analog = mode_analog_mask(mode_ff);
   wire [NUM_PINS-1:0] analog_pins = {{(NUM_PINS-3){1'b0}}, cmp_analog};

   reg [7:0] nxt_rdata;
   always @* begin
      nxt_rdata = 8'h00;
      if (reg_rd_i) begin
         case (reg_addr_i)
            `CMP_CTRL_ADDR:
               nxt_rdata = {1'b0, result, 1'b0, invert_ff, insel_ff, mode_ff};
            `REF_CTRL_ADDR:
               nxt_rdata = {ref_en_ff, 1'b0, ref_range_ff, 1'b0, ref_level_ff};
            `PORT_DIR_ADDR:
               nxt_rdata = {{(8-NUM_PINS){1'b0}}, port_dir_ff};
            `PORT_PINS_ADDR:
               nxt_rdata = {{(8-NUM_PINS){1'b0}}, pin_sync_ff & ~analog_pins};
            `CHANGE_FLAG_ADDR:
               nxt_rdata = {4'h0, flag_ff, 3'h0};
            default:
               nxt_rdata = 8'h00;
         endcase
      end
   end

   always @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs to the analog side and the pin

   wire out_mode = mode_has_output(mode_ff);

   assign reg_rdata_o              = rdata_ff;
   assign comparator_mode_o        = mode_ff;
   assign comparator_on_o          = cmp_on;
   assign input_select_o           = insel_ff;
   assign ref_route_o              = cmp_on & mode_uses_ref(mode_ff);
   // the ladder itself sets the voltage from range and level
   assign reference_enable_o       = ref_en_ff;
   assign reference_range_o        = ref_range_ff;
   assign reference_level_o        = ref_level_ff;
   assign pin_analog_o             = analog_pins;
   assign result_valid_o           = cmp_on & ~settling;
   assign comparator_change_flag_o = flag_ff;
   // raw path on purpose: the pin follows the comparator with no clock delay
   assign output_pin_o             = out_mode & (cmp_raw_i ^ invert_ff);
   assign output_pin_oe_b_o        = ~out_mode | port_dir_ff[`OUT_PIN_BIT];

endmodule // comparator_vref_control

/* File: tb/cvc_asserts.sv */
// checker on the comparator block's ports
// assumes the register map header is on the include path
`timescale 1ns/10ps
`include "comparator_vref_control_regs.vh"
module cvc_asserts #(
   parameter NUM_PINS = 6
) (
   // clock, reset and register port
   input wire                core_clk_i,
   input wire                rst_b_i,
   input wire [7:0]          reg_addr_i,
   input wire [7:0]          reg_wdata_i,
   input wire                reg_wr_i,
   // block outputs
   input wire [2:0]          comparator_mode_o,
   input wire                comparator_on_o,
   input wire                ref_route_o,
   input wire                reference_enable_o,
   input wire                reference_range_o,
   input wire [3:0]          reference_level_o,
   input wire [NUM_PINS-1:0] pin_analog_o,
   input wire                result_valid_o,
   input wire                comparator_change_flag_o,
   input wire                output_pin_o,
   input wire                output_pin_oe_b_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   wire [2:0] m = comparator_mode_o;
   wire       out_mode = (m == 3'h1) || (m == 3'h3) || (m == 3'h5);
   wire [2:0] wmode = reg_wdata_i[2:0];
   wire [5:0] wref = {reg_wdata_i[7], reg_wdata_i[5], reg_wdata_i[3:0]};
   wire       flag_wr = reg_wr_i && (reg_addr_i == `CHANGE_FLAG_ADDR);
   ////////////////////////////////////////////////////////////////////////
   // settling: eight cycles is a floor, the real wait is far longer
   sequence mode_change;
      comparator_on_o && !$stable(comparator_mode_o);
   endsequence
   sequence settle_hold;
      !result_valid_o [*8];
   endsequence
   a_settle_low: assert property (mode_change |-> settle_hold) else $error("valid during settle");
   a_valid_on: assert property (result_valid_o |-> comparator_on_o) else $error("valid while off");
   a_pin_quiet: assert property (!out_mode |-> !output_pin_o) else $error("pin driven");
   a_oe_mode: assert property (!output_pin_oe_b_o |-> out_mode) else $error("enable outside output mode");
   a_on_decode: assert property (comparator_on_o == (m != 3'h0 && m != 3'h7)) else $error("on decode");
   a_ref_route: assert property (ref_route_o == (m >= 3'h3 && m <= 3'h6)) else $error("route decode");
   a_analog_map: assert property (pin_analog_o == (m == 3'h0 ? 6'h07 : m == 3'h7 ? 6'h00 : 6'h03))
      else $error("analog map");
   a_mode_write: assert property (reg_wr_i && reg_addr_i == `CMP_CTRL_ADDR |=> m == $past(wmode))
      else $error("mode write");
   a_ref_write: assert property (reg_wr_i && reg_addr_i == `REF_CTRL_ADDR |=>
      {reference_enable_o, reference_range_o, reference_level_o} == $past(wref)) else $error("ref write");
   a_flag_clear: assert property ($fell(comparator_change_flag_o) |-> $past(flag_wr))
      else $error("flag dropped");
endmodule // cvc_asserts
bind comparator_vref_control cvc_asserts #(.NUM_PINS(NUM_PINS)) chk (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .comparator_mode_o(comparator_mode_o),
   .comparator_on_o(comparator_on_o), .ref_route_o(ref_route_o), .reference_enable_o(reference_enable_o),
   .reference_range_o(reference_range_o), .reference_level_o(reference_level_o), .pin_analog_o(pin_analog_o),
   .result_valid_o(result_valid_o), .comparator_change_flag_o(comparator_change_flag_o),
   .output_pin_o(output_pin_o), .output_pin_oe_b_o(output_pin_oe_b_o));

/* File: tb/analog_side.sv */
// analog side: comparator inputs and port pin levels
// assumes the bench sets levels in millivolts; no clock on this side
`timescale 1ns/10ps
module analog_side (
   // levels from the bench
   input  wire [15:0] pos_mv_i,
   input  wire [15:0] neg_mv_i,
   input  wire [5:0]  pin_lvl_i,
   // to the block
   output wire        cmp_raw_o,
   output wire [5:0]  pin_o
);
   // ties are not modelled: equal levels read low
   assign cmp_raw_o = pos_mv_i > neg_mv_i;
   assign pin_o     = pin_lvl_i;
endmodule // analog_side

/* File: tb/comparator_vref_control_test.sv */
// bench for the comparator block: register calls with expected values
// assumes the partner model and the register map header
`timescale 1ns/10ps
`include "comparator_vref_control_regs.vh"
module comparator_vref_control_test;
   reg         core_clk_i;
   reg         rst_b_i;
   reg  [7:0]  addr, wdata;
   reg         wr, rd;
   reg  [15:0] pos_mv, neg_mv;
   reg  [5:0]  pin_lvl;
   wire [7:0]  rdata;
   wire [2:0]  mode;
   wire        on, route, ren, rrng, valid, flag, opin, oe_b, raw, insel;
   wire [3:0]  rlvl;
   wire [5:0]  analog, pins;
   integer     bad_count, checked, i;
   analog_side far (.pos_mv_i(pos_mv), .neg_mv_i(neg_mv), .pin_lvl_i(pin_lvl), .cmp_raw_o(raw), .pin_o(pins));
   comparator_vref_control uut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .cmp_raw_i(raw), .pin_in_i(pins),
      .comparator_mode_o(mode), .comparator_on_o(on), .input_select_o(insel), .ref_route_o(route),
      .reference_enable_o(ren), .reference_range_o(rrng), .reference_level_o(rlvl), .pin_analog_o(analog),
      .result_valid_o(valid), .comparator_change_flag_o(flag), .output_pin_o(opin), .output_pin_oe_b_o(oe_b));
   ////////////////////////////////////////////////////////////////////////
   task chk(input [8*8-1:0] name, input [7:0] exp, input [7:0] got);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   task wr_reg(input [7:0] a, input [7:0] v);
      begin
         @(posedge core_clk_i);
         addr <= a;
         wdata <= v;
         wr <= 1'b1;
         @(posedge core_clk_i);
         wr <= 1'b0;
         #1;
      end
   endtask
   // read data stand only in the cycle after the strobe
   task rd_chk(input [8*8-1:0] name, input [7:0] a, input [7:0] exp);
      begin
         @(posedge core_clk_i);
         addr <= a;
         rd <= 1'b1;
         @(posedge core_clk_i);
         rd <= 1'b0;
         #1;
         chk(name, exp, rdata);
      end
   endtask
   task do_reset;
      begin
         rst_b_i <= 1'b0;
         repeat (2) @(posedge core_clk_i);
         rst_b_i <= 1'b1;
      end
   endtask
   task conclude;
      begin
         $display("counts: %0d checked, %0d bad", checked, bad_count);
         if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   initial begin
      #100000;
      bad_count = bad_count + 1;
      conclude;
   end
   initial begin
      rst_b_i = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      pos_mv = 16'd1000;
      neg_mv = 16'd500;
      pin_lvl = 6'h3f;
      bad_count = 0;
      checked = 0;
      do_reset;
      rd_chk("cmp_ctrl", `CMP_CTRL_ADDR, 8'h00);
      rd_chk("ref_ctrl", `REF_CTRL_ADDR, 8'h00);
      rd_chk("port_dir", `PORT_DIR_ADDR, 8'h3f);
      chk("analog", 8'h07, {2'b00, analog});
      rd_chk("unmapped", 8'h42, 8'h00);
      $display("test reset done");
      wr_reg(`REF_CTRL_ADDR, 8'hff);
      rd_chk("ref_ctrl", `REF_CTRL_ADDR, 8'haf);
      chk("ref_out", 8'h3f, {2'b00, ren, rrng, rlvl});
      wr_reg(`REF_CTRL_ADDR, 8'h4a);
      chk("ref_out", 8'h0a, {2'b00, ren, rrng, rlvl});
      $display("test reference done");
      // flag ignored as an event while modes are swept
      for (i = 0; i < 8; i = i + 1) begin
         wr_reg(`CMP_CTRL_ADDR, i[7:0]);
         chk("on", (8'h7e >> i) & 8'h01, {7'h0, on});
         chk("route", (8'h78 >> i) & 8'h01, {7'h0, route});
         chk("analog", i == 0 ? 8'h07 : i == 7 ? 8'h00 : 8'h03, {2'b00, analog});
      end
      $display("test modes done");
      wr_reg(`CMP_CTRL_ADDR, 8'h01);
      chk("valid", 8'h00, {7'h0, valid});
      i = 0;
      while (valid !== 1'b1 && i < 1100) begin
         @(posedge core_clk_i);
         #1;
         i = i + 1;
      end
      chk("settled", 8'h01, {7'h0, i > 990 && i < 1005});
      rd_chk("cmp_ctrl", `CMP_CTRL_ADDR, 8'h41);
      chk("out_pin", 8'h01, {7'h0, opin});
      wr_reg(`CMP_CTRL_ADDR, 8'h11);
      rd_chk("cmp_ctrl", `CMP_CTRL_ADDR, 8'h11);
      chk("out_pin", 8'h00, {7'h0, opin});
      wr_reg(`CMP_CTRL_ADDR, 8'h51);
      rd_chk("cmp_ctrl", `CMP_CTRL_ADDR, 8'h11);
      chk("oe_b", 8'h01, {7'h0, oe_b});
      wr_reg(`PORT_DIR_ADDR, 8'h3b);
      chk("oe_b", 8'h00, {7'h0, oe_b});
      rd_chk("pins", `PORT_PINS_ADDR, 8'h3c);
      $display("test result done");
      wr_reg(`CHANGE_FLAG_ADDR, 8'h00);
      chk("flag", 8'h00, {7'h0, flag});
      pos_mv <= 16'd0;
      repeat (5) @(posedge core_clk_i);
      chk("flag", 8'h01, {7'h0, flag});
      wr_reg(`CHANGE_FLAG_ADDR, 8'h00);
      chk("flag", 8'h01, {7'h0, flag});
      rd_chk("cmp_ctrl", `CMP_CTRL_ADDR, 8'h51);
      wr_reg(`CHANGE_FLAG_ADDR, 8'h00);
      chk("flag", 8'h00, {7'h0, flag});
      $display("test flag done");
      wr_reg(`CMP_CTRL_ADDR, 8'h08);
      chk("insel", 8'h01, {7'h0, insel});
      rd_chk("cmp_ctrl", `CMP_CTRL_ADDR, 8'h08);
      @(posedge core_clk_i);
      do_reset;
      #1;
      chk("insel", 8'h00, {7'h0, insel});
      rd_chk("cmp_ctrl", `CMP_CTRL_ADDR, 8'h00);
      rd_chk("ref_ctrl", `REF_CTRL_ADDR, 8'h00);
      chk("oe_b", 8'h01, {7'h0, oe_b});
      $display("test second reset done");
      conclude;
   end
endmodule // comparator_vref_control_test
